// ==== rtl/ccs_cfg_regs.sv ====
`timescale 1ns/100ps

module ccs_cfg_regs
   import ccs_pkg::*;
(
   input  wire logic     CLOCK,                // system clock, 100 MHz
   input  wire logic     SRST,                 // synchronous reset, high
   input  wire logic     CE,                   // clock enable, freezes state when low
   input  wire ccs_acc_s CFG_ACC,              // host configuration access
   output logic [7:0]    CFG_RDATA,            // registered read byte
   output logic          CFG_RVALID,           // read data valid, one cycle
   input  wire logic [5:0] MODE_INDEX,         // mode index from option register
   input  wire logic     DIRECT_DISK,          // card strapped to direct disk mode
   input  wire logic     READY_INT,            // internal ready (1) / busy (0)
   input  wire logic     WRITE_PROTECT,        // write protect state, 1 protected
   input  wire logic     IRQ_SOURCE,           // raw interrupt condition, held until serviced
   input  wire logic     IRQ_DISABLE_N,        // device control interrupt-disable bit, 1 disables
   output logic          STATUS_CHANGE_OUT_N,  // status change pin, low active
   output logic          INTERRUPT_REQUEST_N,  // ready / interrupt request pin, low active
   output logic          POWER_DOWN,           // card in sleep state
   output logic          NARROW_BUS_ONLY,      // host limited to 8-bit I/O cycles
   output logic          COPY_NUMBER_FIELD     // card copy number
);

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   // full 11-bit compare, so aliases of the three offsets do not decode
   // one decoder for all strobes so reads and writes agree on the map
   function automatic logic hits(input logic [10:0] addr, input logic [10:0] off);
      hits = (addr == off);
   endfunction : hits

   // assemble a readable byte from stored bits and the fixed ones
   function automatic logic [7:0] with_fixed(input logic [7:0] stored, input logic [7:0] fixed);
      with_fixed = stored | fixed;
   endfunction : with_fixed

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   // access gating and strobes
   logic       access_ok;
   logic       io_mode;
   logic       wr_status;
   logic       wr_pinrep;
   logic       wr_socket;
   logic       rd_any;

   // stored host bits
   logic       sig_enable;
   logic       narrow;
   logic       copy_bit;

   // live and latched status
   logic       int_pending;
   logic       change_flag;
   logic [1:0] chg_latch;
   logic [1:0] chg_live;
   logic [1:0] chg_wbit;

   // register images and read path
   logic [7:0] status_byte;
   logic [7:0] pinrep_byte;
   logic [7:0] socket_byte;
   logic [7:0] next_rdata;

   // power state
   ccs_pwr_e   pwr_state;
   ccs_pwr_e   next_pwr_state;

   ////////////////////////////////////////////////////////////////////////////
   // mode and access gating

   // the index is a level from the option register; a new value acts from the next edge
   // nonzero mode index selects one of the I/O interfaces
   assign io_mode   = (MODE_INDEX != CCS_IDX_MEMORY);
   // in direct disk mode the config space is not decoded at all
   assign access_ok = !DIRECT_DISK;

   // write strobes per register and one read strobe for all offsets
   assign wr_status = access_ok && CFG_ACC.wr && hits(CFG_ACC.addr, CCS_OFF_STATUS);
   assign wr_pinrep = access_ok && CFG_ACC.wr && hits(CFG_ACC.addr, CCS_OFF_PINREP);
   assign wr_socket = access_ok && CFG_ACC.wr && hits(CFG_ACC.addr, CCS_OFF_SOCKET);
   assign rd_any    = access_ok && CFG_ACC.rd;

   ////////////////////////////////////////////////////////////////////////////
   // status register host bits

   // the change flag and pending bit are not writable; their write data is dropped
   // status-change enable and narrow-bus bits are plain host storage
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         sig_enable <= CCS_RST_STATUS[CCS_ST_SIGEN];
         narrow     <= CCS_RST_STATUS[CCS_ST_NARROW];
      end else if (CE && wr_status) begin
         sig_enable <= CFG_ACC.wdata[CCS_ST_SIGEN];
         narrow     <= CFG_ACC.wdata[CCS_ST_NARROW];
      end
   end

   assign NARROW_BUS_ONLY = narrow;

   ////////////////////////////////////////////////////////////////////////////
   // power state

   // the host alone wakes the card; nothing inside the block leaves sleep on its own
   // the power-down bit is the state itself, so a read always shows where the card is
   always_comb begin
      next_pwr_state = pwr_state;
      if (wr_status) begin
         if (CFG_ACC.wdata[CCS_ST_PWRDN]) begin
            next_pwr_state = CCS_PWR_SLEEP;
         end else begin
            next_pwr_state = CCS_PWR_IDLE;
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         pwr_state <= CCS_PWR_IDLE;
      end else if (CE) begin
         pwr_state <= next_pwr_state;
      end
   end

   always_comb begin
      case (pwr_state)
         CCS_PWR_IDLE:  POWER_DOWN = 1'b0;
         CCS_PWR_SLEEP: POWER_DOWN = 1'b1;
         default:       POWER_DOWN = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt pending

   // registered: one cycle of latency is traded for a glitch-free bit
   // follows the source, so it drops only once the cause is serviced;
   // masked to zero while the device control bit disables interrupts
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         int_pending <= CCS_RST_STATUS[CCS_ST_INTPEND];
      end else if (CE) begin
         int_pending <= IRQ_SOURCE && !IRQ_DISABLE_N;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // change latches for ready and write protect

   assign chg_live[1] = READY_INT;
   assign chg_live[0] = WRITE_PROTECT;
   assign chg_wbit[1] = CFG_ACC.wdata[CCS_PR_RDY_CHG];
   assign chg_wbit[0] = CFG_ACC.wdata[CCS_PR_WP_CHG];

   // index 1 is ready, index 0 is write protect; both share the same behaviour
   // one host write strobe serves both; writing 1 sets a latch on purpose
   for (genvar g = 0; g < 2; g++) begin : g_chg
      ccs_chg_latch u_latch (
         .CLOCK  (CLOCK),
         .SRST   (SRST),
         .CE     (CE),
         .LIVE   (chg_live[g]),
         .WR_EN  (wr_pinrep),
         .WR_BIT (chg_wbit[g]),
         .LATCH  (chg_latch[g])
      );
   end

   // the change flag mirrors the ready-change latch only
   assign change_flag = chg_latch[1];

   ////////////////////////////////////////////////////////////////////////////
   // socket and copy register

   // only bit 4 is stored; bits 3 and 2 read as fixed ones from the image
   // copy number should be set before the mode index; the card cannot enforce it
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         copy_bit <= CCS_RST_SOCKET[CCS_SC_COPY];
      end else if (CE && wr_socket) begin
         copy_bit <= CFG_ACC.wdata[CCS_SC_COPY];
      end
   end

   assign COPY_NUMBER_FIELD = copy_bit;

   ////////////////////////////////////////////////////////////////////////////
   // register images

   // live bits read the inputs directly, so host writes to them land nowhere
   // fixed bits come from constants and never from storage
   always_comb begin
      status_byte = CCS_RST_STATUS;
      status_byte[CCS_ST_CHANGE]  = change_flag;
      status_byte[CCS_ST_SIGEN]   = sig_enable;
      status_byte[CCS_ST_NARROW]  = narrow;
      status_byte[CCS_ST_PWRDN]   = POWER_DOWN;
      status_byte[CCS_ST_INTPEND] = int_pending;
      status_byte = with_fixed(status_byte, CCS_FIX_STATUS);
   end

   always_comb begin
      pinrep_byte = 8'h00;
      pinrep_byte[CCS_PR_RDY_CHG]  = chg_latch[1];
      pinrep_byte[CCS_PR_WP_CHG]   = chg_latch[0];
      pinrep_byte[CCS_PR_RDY_LIVE] = READY_INT;
      pinrep_byte[CCS_PR_WP_LIVE]  = WRITE_PROTECT;
      pinrep_byte = with_fixed(pinrep_byte, CCS_FIX_PINREP);
   end

   always_comb begin
      socket_byte = 8'h00;
      socket_byte[CCS_SC_COPY] = copy_bit;
      socket_byte = with_fixed(socket_byte, CCS_FIX_SOCKET);
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path

   // a read in the cycle of a write returns the image from before that write
   // unknown offsets answer zero so a probing host sees an empty slot
   always_comb begin
      if (hits(CFG_ACC.addr, CCS_OFF_STATUS)) begin
         next_rdata = status_byte;
      end else if (hits(CFG_ACC.addr, CCS_OFF_PINREP)) begin
         next_rdata = pinrep_byte;
      end else if (hits(CFG_ACC.addr, CCS_OFF_SOCKET)) begin
         next_rdata = socket_byte;
      end else begin
         next_rdata = CCS_UNMAPPED;
      end
   end

   // read data is held until the next read so slow hosts can sample late
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         CFG_RDATA <= 8'h00;
      end else if (CE && rd_any) begin
         CFG_RDATA <= next_rdata;
      end
   end

   // one pulse per taken read; a refused read leaves no trace
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         CFG_RVALID <= 1'b0;
      end else if (CE) begin
         CFG_RVALID <= rd_any;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // card pins

   // a memory-mode card leaves the pin high even with the flag and enable set
   // status change only acts in an I/O interface; registered to keep the pin glitch free
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         STATUS_CHANGE_OUT_N <= 1'b1;
      end else if (CE) begin
         if (io_mode && sig_enable && change_flag) begin
            STATUS_CHANGE_OUT_N <= 1'b0;
         end else begin
            STATUS_CHANGE_OUT_N <= 1'b1;
         end
      end
   end

   // in I/O mode the ready pin is reused as interrupt request, otherwise it shows busy
   // in memory mode the pin is the plain ready line that the host polls
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         INTERRUPT_REQUEST_N <= 1'b1;
      end else if (CE) begin
         if (io_mode) begin
            INTERRUPT_REQUEST_N <= !int_pending;
         end else begin
            INTERRUPT_REQUEST_N <= READY_INT;
         end
      end
   end

endmodule : ccs_cfg_regs

// ==== rtl/ccs_chg_latch.sv ====
`timescale 1ns/100ps

module ccs_chg_latch
   import ccs_pkg::*;
(
   input  wire logic CLOCK,   // system clock
   input  wire logic SRST,    // synchronous reset, high
   input  wire logic CE,      // clock enable
   input  wire logic LIVE,    // live status level
   input  wire logic WR_EN,   // host write to this latch
   input  wire logic WR_BIT,  // value written by the host
   output logic      LATCH    // sticky change latch
);

   logic live_prev;

   // remember the last level so a change of state can be seen; reset loads the
   // level itself, so a card that is already ready at release shows no false change
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         live_prev <= LIVE;
      end else if (CE) begin
         live_prev <= LIVE;
      end
   end

   // a change sets the latch; it wins over a host write of zero in the same cycle
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         LATCH <= 1'b0;
      end else if (CE) begin
         if (LIVE != live_prev) begin
            LATCH <= 1'b1;
         end else if (WR_EN) begin
            LATCH <= WR_BIT;
         end
      end
   end

endmodule : ccs_chg_latch

// ==== rtl/ccs_pkg.sv ====
package ccs_pkg;

   // attribute-space byte offsets of the three registers
   localparam logic [10:0] CCS_OFF_STATUS = 11'h202;
   localparam logic [10:0] CCS_OFF_PINREP = 11'h204;
   localparam logic [10:0] CCS_OFF_SOCKET = 11'h206;

   // values after reset
   localparam logic [7:0] CCS_RST_STATUS = 8'h00;
   localparam logic [7:0] CCS_RST_PINREP = 8'h0c;
   localparam logic [7:0] CCS_RST_SOCKET = 8'h00;

   // status register field positions
   localparam int CCS_ST_CHANGE   = 7;
   localparam int CCS_ST_SIGEN    = 6;
   localparam int CCS_ST_NARROW   = 5;
   localparam int CCS_ST_PWRDN    = 2;
   localparam int CCS_ST_INTPEND  = 1;

   // pin replacement register field positions
   localparam int CCS_PR_RDY_CHG  = 5;
   localparam int CCS_PR_WP_CHG   = 4;
   localparam int CCS_PR_RDY_LIVE = 1;
   localparam int CCS_PR_WP_LIVE  = 0;

   // socket and copy register field position
   localparam int CCS_SC_COPY     = 4;

   // bits that read back fixed ones, all others zero unless stored or read live from an input
   localparam logic [7:0] CCS_FIX_STATUS = 8'h00;
   localparam logic [7:0] CCS_FIX_PINREP = 8'h0c;
   localparam logic [7:0] CCS_FIX_SOCKET = 8'h0c;

   // read data for an address outside the three registers
   localparam logic [7:0] CCS_UNMAPPED   = 8'h00;

   // mode index that means memory card interface
   localparam logic [5:0] CCS_IDX_MEMORY = 6'h00;

   // one host configuration access
   typedef struct packed {
      logic        rd;     // read strobe, one cycle
      logic        wr;     // write strobe, one cycle
      logic [10:0] addr;   // byte offset in attribute space
      logic [7:0]  wdata;  // write byte
   } ccs_acc_s;

   // card power state
   typedef enum logic [1:0] {
      CCS_PWR_IDLE  = 2'b01,
      CCS_PWR_SLEEP = 2'b10
   } ccs_pwr_e;

endpackage : ccs_pkg

// ==== sim/ccs_cfg_checker.sv ====
`timescale 1ns/100ps
// port-level checks of the configuration register block
module ccs_cfg_checker
   import ccs_pkg::*;
(
   input wire logic       CLOCK,               // clock
   input wire logic       SRST,                // reset
   input wire logic       CE,                  // enable
   input wire ccs_acc_s   CFG_ACC,             // access
   input wire logic [7:0] CFG_RDATA,           // read byte
   input wire logic       CFG_RVALID,          // read valid
   input wire logic [5:0] MODE_INDEX,          // mode index
   input wire logic       DIRECT_DISK,         // disk mode
   input wire logic       READY_INT,           // ready
   input wire logic       WRITE_PROTECT,       // protect
   input wire logic       IRQ_SOURCE,          // irq source
   input wire logic       IRQ_DISABLE_N,       // irq disable
   input wire logic       STATUS_CHANGE_OUT_N, // change pin
   input wire logic       INTERRUPT_REQUEST_N, // irq pin
   input wire logic       POWER_DOWN,          // sleep
   input wire logic       NARROW_BUS_ONLY,     // narrow bus
   input wire logic       COPY_NUMBER_FIELD    // copy number
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SRST);
   // an access is taken only when running and not in direct disk mode
   wire logic go = CE && !DIRECT_DISK;
   wire logic io = MODE_INDEX != 6'h00;

   ////////////////////////////////////////////////////////////
   a_read_answer: assert property (go && CFG_ACC.rd |=> CFG_RVALID)
      else $error("taken read got no valid");
   a_read_refused: assert property (CE && !(go && CFG_ACC.rd) |=> !CFG_RVALID)
      else $error("valid without a taken read");
   a_pwr_write: assert property (go && CFG_ACC.wr && CFG_ACC.addr == CCS_OFF_STATUS
      |=> POWER_DOWN == $past(CFG_ACC.wdata[CCS_ST_PWRDN])) else $error("sleep bit not stored");
   a_copy_write: assert property (go && CFG_ACC.wr && CFG_ACC.addr == CCS_OFF_SOCKET
      |=> COPY_NUMBER_FIELD == $past(CFG_ACC.wdata[CCS_SC_COPY])) else $error("copy bit not stored");
   a_disk_nowrite: assert property (DIRECT_DISK && CFG_ACC.wr
      |=> $stable(POWER_DOWN) && $stable(COPY_NUMBER_FIELD)) else $error("write taken in disk mode");
   // a memory-mode card never signals a status change
   a_sts_memory: assert property ((CE && !io)[*2] |=> STATUS_CHANGE_OUT_N)
      else $error("change pin low in memory mode");
   a_irq_pending: assert property ((CE && io && IRQ_SOURCE && !IRQ_DISABLE_N)[*2]
      |=> !INTERRUPT_REQUEST_N) else $error("irq pin not low");
   a_irq_masked: assert property ((CE && io && IRQ_DISABLE_N)[*2] |=> INTERRUPT_REQUEST_N)
      else $error("irq pin low while disabled");
   a_irq_serviced: assert property ((CE && io && !IRQ_SOURCE)[*2] |=> INTERRUPT_REQUEST_N)
      else $error("irq pin low after service");
endmodule : ccs_cfg_checker

bind ccs_cfg_regs ccs_cfg_checker chk_u (.CLOCK, .SRST, .CE, .CFG_ACC, .CFG_RDATA, .CFG_RVALID, .MODE_INDEX,
   .DIRECT_DISK, .READY_INT, .WRITE_PROTECT, .IRQ_SOURCE, .IRQ_DISABLE_N, .STATUS_CHANGE_OUT_N,
   .INTERRUPT_REQUEST_N, .POWER_DOWN, .NARROW_BUS_ONLY, .COPY_NUMBER_FIELD);

// ==== sim/ccs_host_model.sv ====
`timescale 1ns/100ps
// host socket adapter: one configuration access per call
module ccs_host_model
   import ccs_pkg::*;
(
   input  wire logic CLOCK, // system clock
   output ccs_acc_s  ACC    // access toward the card
);
   initial begin
      ACC = '0;
   end
   // drive after a falling edge and hold over the taking edge; a released
   // bus shows inverted address and data so stale values cannot pass
   task automatic access(input logic r, input logic w, input logic [10:0] a, input logic [7:0] d);
      @(negedge CLOCK);
      ACC = {r, w, a, d};
      @(negedge CLOCK);
      ACC = {2'b00, ~a, ~d};
   endtask : access
endmodule : ccs_host_model

// ==== sim/test_ccs_cfg_regs.sv ====
`timescale 1ns/100ps
module test_ccs_cfg_regs;
   import ccs_pkg::*;
   logic        CLOCK = 1'b0;
   logic        SRST, CE, disk, rdy, wp, src, dis_n;
   logic [5:0]  mode;
   ccs_acc_s    acc;
   logic [7:0]  rdata, d;
   logic        rvalid, sts_n, irq_n, pwr, narrow, copy;
   logic [7:0]  expq[$];
   logic [31:0] seed = 32'd50328;
   int          fail_count = 0;
   int          n_checks = 0;
   int          cyc = 0;

   always #5 CLOCK = ~CLOCK;

   ccs_host_model host_u (.CLOCK(CLOCK), .ACC(acc));
   ccs_cfg_regs dut_u (.CLOCK(CLOCK), .SRST(SRST), .CE(CE), .CFG_ACC(acc), .CFG_RDATA(rdata),
      .CFG_RVALID(rvalid), .MODE_INDEX(mode), .DIRECT_DISK(disk), .READY_INT(rdy), .WRITE_PROTECT(wp),
      .IRQ_SOURCE(src), .IRQ_DISABLE_N(dis_n), .STATUS_CHANGE_OUT_N(sts_n), .INTERRUPT_REQUEST_N(irq_n),
      .POWER_DOWN(pwr), .NARROW_BUS_ONLY(narrow), .COPY_NUMBER_FIELD(copy));

   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // a read notes its expected byte before the request goes out
   task automatic rd(input logic [10:0] a, input logic [7:0] e);
      expq.push_back(e);
      host_u.access(1'b1, 1'b0, a, 8'h00);
   endtask : rd

   task automatic wr(input logic [10:0] a, input logic [7:0] v);
      host_u.access(1'b0, 1'b1, a, v);
   endtask : wr

   task automatic idle(input int n);
      repeat (n) @(negedge CLOCK);
   endtask : idle

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : close_out

   // read valid stands one cycle, so the held read data is taken at the falling edge while it is high
   always @(negedge CLOCK) begin
      if (rvalid === 1'b1) begin
         chk(rdata, expq.size() > 0 ? expq.pop_front() : 8'hxx);
      end
   end

   // hang guard, well above the roughly 110 cycles the run needs
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      SRST = 1'b1; CE = 1'b1; mode = 6'h00; disk = 1'b0;
      rdy = 1'b0; wp = 1'b0; src = 1'b0; dis_n = 1'b0;
      repeat (5) @(negedge CLOCK);
      SRST = 1'b0;
      rd(CCS_OFF_STATUS, 8'h00);
      rd(CCS_OFF_PINREP, 8'h0c);
      rd(CCS_OFF_SOCKET, 8'h0c);
      rd(11'h208, 8'h00);
      $display("reset images done");
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         d = seed[7:0];
         wr(CCS_OFF_STATUS, d);
         chk({7'h0, pwr}, {7'h0, d[2]});
         chk({7'h0, narrow}, {7'h0, d[5]});
         rd(CCS_OFF_STATUS, d & 8'h64);
         wr(CCS_OFF_SOCKET, d);
         chk({7'h0, copy}, {7'h0, d[4]});
         rd(CCS_OFF_SOCKET, (d & 8'h10) | 8'h0c);
      end
      $display("random writes done");
      wr(CCS_OFF_STATUS, 8'h40);
      mode = 6'h01;
      rdy = 1'b1;
      idle(4);
      chk({7'h0, sts_n}, 8'h00);
      rd(CCS_OFF_STATUS, 8'hc0);
      rd(CCS_OFF_PINREP, 8'h2e);
      wr(CCS_OFF_STATUS, 8'h00);
      idle(2);
      chk({7'h0, sts_n}, 8'h01);
      wp = 1'b1;
      idle(3);
      rd(CCS_OFF_PINREP, 8'h3f);
      wr(CCS_OFF_PINREP, 8'h00);
      rd(CCS_OFF_PINREP, 8'h0f);
      rd(CCS_OFF_STATUS, 8'h00);
      $display("change latches done");
      src = 1'b1;
      idle(3);
      chk({7'h0, irq_n}, 8'h00);
      rd(CCS_OFF_STATUS, 8'h02);
      dis_n = 1'b1;
      idle(2);
      rd(CCS_OFF_STATUS, 8'h00);
      chk({7'h0, irq_n}, 8'h01);
      dis_n = 1'b0;
      idle(2);
      rd(CCS_OFF_STATUS, 8'h02);
      src = 1'b0;
      idle(2);
      rd(CCS_OFF_STATUS, 8'h00);
      $display("interrupt done");
      disk = 1'b1;
      wr(CCS_OFF_STATUS, 8'h04);
      host_u.access(1'b1, 1'b0, CCS_OFF_STATUS, 8'h00);
      disk = 1'b0;
      CE = 1'b0;
      wr(CCS_OFF_STATUS, 8'h04);
      CE = 1'b1;
      chk({7'h0, pwr}, 8'h00);
      rd(CCS_OFF_STATUS, 8'h00);
      mode = 6'h00;
      rdy = 1'b0;
      idle(3);
      chk({7'h0, irq_n}, 8'h00);
      chk(8'(expq.size()), 8'h00);
      $display("refusal and mirror done");
      wr(CCS_OFF_STATUS, 8'h40);
      idle(2);
      chk({7'h0, sts_n}, 8'h01);
      rd(CCS_OFF_STATUS, 8'hc0);
      rdy = 1'b1;
      wp = 1'b1;
      SRST = 1'b1;
      idle(2);
      SRST = 1'b0;
      rd(CCS_OFF_PINREP, 8'h0f);
      rd(CCS_OFF_STATUS, 8'h00);
      idle(2);
      chk(8'(expq.size()), 8'h00);
      $display("memory mode and reset done");
      close_out();
   end
endmodule : test_ccs_cfg_regs
